// ===== src/timer0_map.svh
`ifndef TIMER0_MAP_SVH
`define TIMER0_MAP_SVH

// register addresses on the plain register port
`define TIMER_COUNT_ADDR 8'h01
`define OPTION_CONFIG_ADDR 8'h10
`define PIN_DIRECTION_ADDR 8'h11
`define SCALER_COMMAND_ADDR 8'h12

// reset values
`define TIMER_COUNT_RESET 8'h00
`define OPTION_CONFIG_RESET 8'hFF
`define PIN_DIRECTION_RESET 4'hF
`define SCALER_RESET 8'h00
`define READ_IDLE 8'h00

// field positions
`define CMD_WDT_CLEAR_BIT 0
`define COUNT_PIN_DIR_BIT 2

// instruction cycles of increment suppression after a count write
`define WRITE_INHIBIT_CYCLES 2'h2
`define INHIBIT_NONE 2'h0
`define INHIBIT_STEP 2'h1

`endif

// ===== src/timer0_pkg.sv
package timer0_pkg;

    // option register layout, msb first
    typedef struct packed {
        logic wake_disable;
        logic pullup_disable;
        logic count_source_select;
        logic source_edge_select;
        logic scaler_assignment;
        logic [2:0] scale_ratio;
    } option_t;

    // one request on the register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // phases of one instruction cycle, one oscillator period each
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_t;

endpackage : timer0_pkg

// ===== src/timer0_with_shared_prescaler.sv
`timescale 1ns/10ps
`include "timer0_map.svh"

module timer0_with_shared_prescaler
    import timer0_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic external_count_pin,
    input wire logic pin_data,
    output logic count_pin_out,
    output logic count_pin_oe_n,
    output logic [3:0] pin_dir_eff,
    input wire logic wdt_base_tick,
    output logic wdt_scaled_tick,
    output logic wdt_clear
);

    // decoded write to one register address
    function automatic logic wr_hit(input bus_req_t req, input logic [7:0] addr);
        wr_hit = req.wr && (req.addr == addr);
    endfunction : wr_hit

    // decoded read of one register address
    function automatic logic rd_hit(input bus_req_t req, input logic [7:0] addr);
        rd_hit = req.rd && (req.addr == addr);
    endfunction : rd_hit

    phase_t phase_q;
    option_t option_q;
    logic [3:0] pin_direction_q;
    logic [7:0] timer_count_q;
    logic [7:0] scaler_q;
    logic [1:0] inhibit_q;
    logic pin_meta_q;
    logic pin_sync_q;
    logic src_prev_q;
    logic sample_q;
    logic inc_q;
    logic tap_prev_q;
    logic [7:0] rdata_q;
    logic pin_out_q;
    logic wdt_tick_q;
    logic wdt_clear_q;

    logic count_wr;
    logic option_wr;
    logic dir_wr;
    logic cmd_wr;
    logic wdt_clear_cmd;
    logic src_lvl;
    logic src_rise;
    logic scaler_tap;
    logic scaler_to_timer;
    logic sample_point;
    logic sample_lvl;
    logic scaler_clear;
    logic scaler_event;
    logic cycle_end;

    // register port decode
    assign count_wr = wr_hit(bus_req, `TIMER_COUNT_ADDR);
    assign option_wr = wr_hit(bus_req, `OPTION_CONFIG_ADDR);
    assign dir_wr = wr_hit(bus_req, `PIN_DIRECTION_ADDR);
    assign cmd_wr = wr_hit(bus_req, `SCALER_COMMAND_ADDR);
    assign wdt_clear_cmd = cmd_wr && bus_req.wdata[`CMD_WDT_CLEAR_BIT];

    // scaler ownership, one party only
    assign scaler_to_timer = !option_q.scaler_assignment;

    // phase sequencer: sys_clk is the oscillator, four phases per instruction
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            phase_q <= PH_Q1;
        end
        else
        begin
            unique case (phase_q)
                PH_Q1: phase_q <= PH_Q2;
                PH_Q2: phase_q <= PH_Q3;
                PH_Q3: phase_q <= PH_Q4;
                PH_Q4: phase_q <= PH_Q1;
            endcase
        end
    end

    assign cycle_end = (phase_q == PH_Q4);
    assign sample_point = (phase_q == PH_Q2) || (phase_q == PH_Q4);

    // option register, write only
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            option_q <= option_t'(`OPTION_CONFIG_RESET);
        end
        else if (option_wr)
        begin
            option_q <= option_t'(bus_req.wdata);
        end
    end

    // pin direction register, write only
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pin_direction_q <= `PIN_DIRECTION_RESET;
        end
        else if (dir_wr)
        begin
            pin_direction_q <= bus_req.wdata[3:0];
        end
    end

    // pin output latch from the port logic
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pin_out_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= pin_data;
        end
    end

    // counter mode overrides the count pin direction to input
    always_comb
    begin
        pin_dir_eff = pin_direction_q;
        if (option_q.count_source_select)
        begin
            pin_dir_eff[`COUNT_PIN_DIR_BIT] = 1'b1;
        end
    end

    assign count_pin_oe_n = pin_dir_eff[`COUNT_PIN_DIR_BIT];
    assign count_pin_out = pin_out_q;

    // two flip-flop synchroniser on the count pin
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= external_count_pin;
            pin_sync_q <= pin_meta_q;
        end
    end

    // source level: instruction clock or pin with polarity flip
    always_comb
    begin
        if (option_q.count_source_select)
        begin
            src_lvl = pin_sync_q ^ option_q.source_edge_select;
        end
        else
        begin
            src_lvl = (phase_q == PH_Q3) || (phase_q == PH_Q4);
        end
    end

    // remember source level to find its counted edge
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            src_prev_q <= 1'b1; // no false counted edge right after reset
        end
        else
        begin
            src_prev_q <= src_lvl;
        end
    end

    assign src_rise = src_lvl && !src_prev_q;

    // scaler clear and count events for whichever party owns it
    assign scaler_clear = (count_wr && scaler_to_timer)
        || (wdt_clear_cmd && !scaler_to_timer);
    assign scaler_event = scaler_to_timer ? src_rise : wdt_base_tick;

    // shared 8-bit scaler, no software path to its value
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            scaler_q <= `SCALER_RESET;
        end
        else if (scaler_clear)
        begin
            scaler_q <= `SCALER_RESET;
        end
        else if (scaler_event)
        begin
            scaler_q <= scaler_q + 8'h01;
        end
    end

    // tap bit toggles every 2^ratio events, so output is symmetric
    assign scaler_tap = scaler_q[option_q.scale_ratio];

    // scaler output when owned by timer, raw source otherwise
    assign sample_lvl = scaler_to_timer ? scaler_tap : src_lvl;

    // sample in Q2 and Q4, flag a rising sample as one increment
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            sample_q <= 1'b1; // no false increment right after reset
            inc_q <= 1'b0;
        end
        else
        begin
            inc_q <= 1'b0;
            if (sample_point)
            begin
                sample_q <= sample_lvl;
                inc_q <= sample_lvl && !sample_q;
            end
        end
    end

    // write inhibit counts down at instruction cycle ends
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            inhibit_q <= `INHIBIT_NONE;
        end
        else if (count_wr)
        begin
            // the write's own cycle end must not use up one of the two held cycles
            inhibit_q <= cycle_end ? `WRITE_INHIBIT_CYCLES
                : (`WRITE_INHIBIT_CYCLES + `INHIBIT_STEP);
        end
        else if (cycle_end && (inhibit_q != `INHIBIT_NONE))
        begin
            inhibit_q <= inhibit_q - `INHIBIT_STEP;
        end
    end

    // timer count: software write wins over an increment
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            timer_count_q <= `TIMER_COUNT_RESET;
        end
        else if (count_wr)
        begin
            timer_count_q <= bus_req.wdata;
        end
        else if (inc_q && (inhibit_q == `INHIBIT_NONE))
        begin
            timer_count_q <= timer_count_q + 8'h01;
        end
    end

    // watchdog side: scaled tick when owned, plain tick otherwise
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            tap_prev_q <= 1'b0;
            wdt_tick_q <= 1'b0;
        end
        else
        begin
            tap_prev_q <= scaler_tap;
            if (scaler_to_timer)
            begin
                wdt_tick_q <= wdt_base_tick;
            end
            else
            begin
                wdt_tick_q <= scaler_tap && !tap_prev_q;
            end
        end
    end

    assign wdt_scaled_tick = wdt_tick_q;

    // watchdog clear pulse handed to the watchdog counter
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            wdt_clear_q <= 1'b0;
        end
        else
        begin
            wdt_clear_q <= wdt_clear_cmd;
        end
    end

    assign wdt_clear = wdt_clear_q;

    // read data one cycle after the strobe; write-only registers read zero
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rdata_q <= `READ_IDLE;
        end
        else if (rd_hit(bus_req, `TIMER_COUNT_ADDR))
        begin
            rdata_q <= timer_count_q;
        end
        else
        begin
            rdata_q <= `READ_IDLE;
        end
    end

    assign bus_rdata = rdata_q;

endmodule : timer0_with_shared_prescaler

// ===== testbench/count_source.sv
`timescale 1ns/10ps
module count_source
(
    input wire logic go,
    input wire logic [7:0] edges,
    output logic pin,
    output logic busy
);
    initial pin = 1'b0;
    initial busy = 1'b0;
    // a burst of level changes 16 ns apart; the pin stands still between bursts
    always @(posedge go)
    begin
        busy = 1'b1;
        #5;
        repeat (edges) #16 pin = ~pin;
        busy = 1'b0;
    end
endmodule : count_source

// ===== testbench/timer0_with_shared_prescaler_monitor.sv
`timescale 1ns/10ps
module timer0_monitor
    import timer0_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic count_pin_oe_n,
    input wire logic [3:0] pin_dir_eff,
    input wire logic wdt_base_tick,
    input wire logic wdt_scaled_tick,
    input wire logic wdt_clear
);
    logic psa_q;
    wire logic [7:0] ad = bus_req.addr;
    wire logic wr = bus_req.wr;
    wire logic rd = bus_req.rd;
    wire logic clr = wr && ad == 8'h12 && bus_req.wdata[0];
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // shadow of the scaler assignment bit
    always_ff @(posedge sys_clk)
        if (!nrst)
            psa_q <= 1'b1;
        else if (wr && ad == 8'h10)
            psa_q <= bus_req.wdata[3];
    a_rdata_idle: assert property (!$past(rd) |-> bus_rdata == 8'h00)
        else $error("read data not idle");
    a_wo_reads: assert property (rd && ad != 8'h01 |=> bus_rdata == 8'h00)
        else $error("write-only read not zero");
    a_write_held: assert property ((wr && ad == 8'h01) ##3 (rd && ad == 8'h01)
        |=> bus_rdata == $past(bus_req.wdata, 4)) else $error("count moved after write");
    a_oe_tied: assert property (count_pin_oe_n == pin_dir_eff[2])
        else $error("pin enable differs from direction");
    a_input_forced: assert property (wr && ad == 8'h10 && bus_req.wdata[5]
        |=> pin_dir_eff[2] && count_pin_oe_n) else $error("count pin not input");
    a_dir_write: assert property (wr && ad == 8'h11
        |=> pin_dir_eff[1:0] == $past(bus_req.wdata[1:0])) else $error("direction not set");
    a_clear_pulse: assert property (wdt_clear == $past(clr))
        else $error("watchdog clear pulse wrong");
    a_tick_fwd: assert property (!psa_q |=> wdt_scaled_tick == $past(wdt_base_tick))
        else $error("watchdog tick not forwarded");
    c_held: cover property ((wr && ad == 8'h01) ##3 (rd && ad == 8'h01));
    c_clear: cover property (wdt_clear);
    c_scaled: cover property (psa_q && wdt_scaled_tick);
endmodule : timer0_monitor

bind timer0_with_shared_prescaler timer0_monitor timer0_monitor_inst (.sys_clk, .nrst,
    .bus_req, .bus_rdata, .count_pin_oe_n, .pin_dir_eff, .wdt_base_tick, .wdt_scaled_tick,
    .wdt_clear);

// ===== testbench/timer0_with_shared_prescaler_tb_top.sv
`timescale 1ns/10ps
module timer0_with_shared_prescaler_tb_top
    import timer0_pkg::*;
;
    logic sys_clk, nrst, pin_data, count_pin_out, count_pin_oe_n, wdt_base_tick;
    logic wdt_scaled_tick, wdt_clear, src_pin, go, busy;
    logic [7:0] bus_rdata, edges;
    logic [3:0] pin_dir_eff;
    bus_req_t bus_req;
    int err_total, tests_run, tick_n;
    // the count pin carries the source unless the device drives it
    wire logic ext_pin = count_pin_oe_n ? src_pin : count_pin_out;
    timer0_with_shared_prescaler timer0_with_shared_prescaler_inst (.sys_clk(sys_clk),
        .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata), .external_count_pin(ext_pin),
        .pin_data(pin_data), .count_pin_out(count_pin_out), .count_pin_oe_n(count_pin_oe_n),
        .pin_dir_eff(pin_dir_eff), .wdt_base_tick(wdt_base_tick),
        .wdt_scaled_tick(wdt_scaled_tick), .wdt_clear(wdt_clear));
    count_source count_source_inst (.go(go), .edges(edges), .pin(src_pin), .busy(busy));
    // oscillator clock, 4 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // scaled watchdog ticks seen so far
    always @(posedge sys_clk)
        if (wdt_scaled_tick === 1'b1)
            tick_n <= tick_n + 1;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk) bus_req.wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk) bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk) bus_req.rd <= 1'b0;
        @(posedge sys_clk) d = bus_rdata;
    endtask : rd_reg
    // reset state, write-only and unmapped reads
    task automatic t_reset;
        logic [7:0] d;
        rd_reg(8'h01, d);
        chk(d, 8'h00);
        rd_reg(8'h10, d);
        chk(d, 8'h00);
        rd_reg(8'h3C, d);
        chk(d, 8'h00);
        chk({3'h0, count_pin_oe_n, pin_dir_eff}, 8'h1F);
    endtask : t_reset
    // direction override in counter mode, driven pin in timer mode
    task automatic t_pins;
        wr_reg(8'h11, 8'h00);
        chk({4'h0, pin_dir_eff}, 8'h04);
        wr_reg(8'h10, 8'h08);
        chk({3'h0, count_pin_oe_n, pin_dir_eff}, 8'h00);
        pin_data <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({7'h00, count_pin_out}, 8'h01);
        pin_data <= 1'b0;
    endtask : t_pins
    // write holds the count, then one step per cycle with a silent wrap
    task automatic t_timer;
        logic [7:0] d;
        int i;
        wr_reg(8'h01, 8'hFF);
        d = 8'hFF;
        for (i = 0; i < 8 && d === 8'hFF; i++)
        begin
            rd_reg(8'h01, d);
            @(posedge sys_clk);
        end
        chk(8'(i > 2), 8'h01);
        chk(d, 8'h00);
        rd_reg(8'h01, d);
        chk(d, 8'h01);
    endtask : t_timer
    // every ratio: exactly one step per ratio span
    task automatic t_scaled;
        logic [7:0] a, b;
        wr_reg(8'h12, 8'h01);
        for (int r = 0; r < 8; r++)
        begin
            wr_reg(8'h10, 8'(r));
            wr_reg(8'h01, 8'h00);
            repeat (40) @(posedge sys_clk);
            rd_reg(8'h01, a);
            repeat ((8 << r) - 3) @(posedge sys_clk);
            rd_reg(8'h01, b);
            chk(b, a + 8'h01);
        end
    endtask : t_scaled
    // external edges: rising, falling, falling through the scaler
    task automatic t_counter;
        logic [23:0] tab [3] = '{24'h280503, 24'h380302, 24'h300802};
        logic [7:0] d;
        int j;
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(8'h10, tab[k][23:16]);
            wr_reg(8'h01, 8'h00);
            repeat (16) @(posedge sys_clk);
            go <= 1'b1;
            edges <= tab[k][15:8];
            @(posedge sys_clk) go <= 1'b0;
            for (j = 0; j < 100 && busy !== 1'b0; j++)
                @(posedge sys_clk);
            chk(8'(j < 100), 8'h01);
            repeat (8) @(posedge sys_clk);
            rd_reg(8'h01, d);
            chk(d, tab[k][7:0]);
        end
    endtask : t_counter
    // watchdog ticks scaled when assigned, forwarded otherwise
    task automatic t_wdt;
        int n0;
        for (int s = 0; s < 2; s++)
        begin
            wr_reg(8'h12, 8'h01);
            wr_reg(8'h10, s ? 8'h00 : 8'h08);
            wr_reg(8'h12, 8'h01);
            n0 = tick_n;
            repeat (8)
            begin
                @(posedge sys_clk) wdt_base_tick <= 1'b1;
                @(posedge sys_clk) wdt_base_tick <= 1'b0;
                repeat (2) @(posedge sys_clk);
            end
            repeat (4) @(posedge sys_clk);
            chk(8'(tick_n - n0), s ? 8'h08 : 8'h04);
        end
    endtask : t_wdt
    // mid-run reset: count and pins back to reset, scaler empty, no false edge
    task automatic t_rerst;
        logic [7:0] d;
        int n0;
        @(posedge sys_clk) nrst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        rd_reg(8'h01, d);
        chk(d, 8'h00);
        rd_reg(8'h01, d);
        chk(d, 8'h00);
        chk({3'h0, count_pin_oe_n, pin_dir_eff}, 8'h1F);
        wr_reg(8'h10, 8'h08);
        n0 = tick_n;
        @(posedge sys_clk) wdt_base_tick <= 1'b1;
        @(posedge sys_clk) wdt_base_tick <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(8'(tick_n - n0), 8'h01);
    endtask : t_rerst
    task automatic finish_test;
        if (err_total == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // main sequence
    initial
    begin
        nrst = 1'b0;
        bus_req = '0;
        pin_data = 1'b0;
        wdt_base_tick = 1'b0;
        go = 1'b0;
        edges = 8'h00;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_pins();
        t_timer();
        t_scaled();
        t_counter();
        t_wdt();
        t_rerst();
        finish_test();
    end
    // hang guard, far beyond the expected run
    initial
    begin
        #100000;
        err_total++;
        finish_test();
    end
endmodule : timer0_with_shared_prescaler_tb_top
